// *** rtl/pisv_defines.svh ***
// offsets, field positions, reset values and defaults of the register slice
`ifndef PISV_DEFINES_SVH
`define PISV_DEFINES_SVH

// ==========================================================
// register offsets
`define PISV_OFS_FLAGS   8'h02
`define PISV_OFS_MASK    8'h03
`define PISV_OFS_STATUS  8'h04
`define PISV_OFS_CAUSE   8'h05
`define PISV_OFS_RAIL1   8'h20
`define PISV_OFS_RAIL2   8'h21

// ==========================================================
// field positions: fault, shut and hot shared by flag and mask registers, then cause bits and the rail code msb
`define PISV_BIT_FAULT   7
`define PISV_BIT_SHUT    3
`define PISV_BIT_HOT     0
`define PISV_BIT_HOSTOFF 3
`define PISV_BIT_UV      2
`define PISV_BIT_PF      1
`define PISV_BIT_CRIT    0
`define PISV_CODE_MSB    6

// ==========================================================
// reset values and the value read at unmapped offsets
`define PISV_RST_MASK    8'hFF
`define PISV_RST_RAIL1   8'h38
`define PISV_RST_RAIL2   8'h00
`define PISV_RD_UNMAPPED 8'h00

// ==========================================================
// serial port
`define PISV_DEV_ADDR    7'h2A
`define PISV_BYTE_BITS   4'h8

`endif

// *** rtl/pisv_pkg.sv ***
// types shared by the register slice
package pisv_pkg;

    // ==========================================================
    // serial port states, one-hot
    typedef enum logic [8:0] {
        ST_IDLE     = 9'h001,
        ST_ADDR     = 9'h002,
        ST_ADDR_ACK = 9'h004,
        ST_PTR      = 9'h008,
        ST_PTR_ACK  = 9'h010,
        ST_WDATA    = 9'h020,
        ST_WDATA_ACK = 9'h040,
        ST_RDATA    = 9'h080,
        ST_RDATA_ACK = 9'h100
    } pisv_state_e;

    // ==========================================================
    // shutdown events from the analog detectors
    typedef struct packed {
        logic hostOff;
        logic undervoltage;
        logic powerFault;
        logic criticalTemp;
    } pisv_events_s;

    typedef logic [7:0] pisv_byte_t;

endpackage

// *** rtl/pisv_sticky_bits.sv ***
// bank of sticky flags, set by hardware and cleared by writing one
`timescale 1ns/1ps
`default_nettype none

module pisv_sticky_bits #(
    parameter int WIDTH = 7
) (
    input  wire logic             clock,
    input  wire logic             rst,
    input  wire logic [WIDTH-1:0] setBits,
    input  wire logic [WIDTH-1:0] clearBits,
    output logic      [WIDTH-1:0] flags
);

    logic [WIDTH-1:0] flags_q;
    logic [WIDTH-1:0] flags_d;

    if (WIDTH < 1) begin : g_bad_width
        $error("pisv_sticky_bits: WIDTH must be at least 1");
    end

    // ==========================================================
    // set wins over a clear in the same cycle so no event is lost
    for (genvar i = 0; i < WIDTH; i++) begin : g_bit
        always_comb begin
            flags_d[i] = setBits[i] | (flags_q[i] & ~clearBits[i]);
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            flags_q <= '0;
        end else begin
            flags_q <= flags_d;
        end
    end

    assign flags = flags_q;

endmodule

`default_nettype wire

// *** rtl/pisv_regs.sv ***
// interrupt, status, shutdown-cause and rail setpoint registers on i2c
`timescale 1ns/1ps
`default_nettype none
`include "pisv_defines.svh"

module pisv_regs
    import pisv_pkg::*;
#(
    parameter logic [6:0] DEV_ADDR = `PISV_DEV_ADDR
) (
    input  wire logic         clock,
    input  wire logic         rst,
    input  wire logic         scl,
    input  wire logic         sdaIn,
    output logic              sdaOut,
    output logic              sdaOe,
    input  wire pisv_events_s shutEvents,
    input  wire logic         hotAbove,
    input  wire logic         standbyRequestN,
    input  wire logic [1:0]   railGoodIn,
    output logic [6:0]        railOneCode,
    output logic [6:0]        railTwoCode,
    output logic [1:0]        powerGood,
    output logic              irqRequest
);

    if (DEV_ADDR == 7'h00 || DEV_ADDR >= 7'h78) begin : g_bad_addr
        $error("pisv_regs: DEV_ADDR lies in a reserved i2c range");
    end

    // ==========================================================
    // register state
    logic [2:0]  mask_q;
    logic [2:0]  mask_d;
    pisv_byte_t  railOne_q;
    pisv_byte_t  railOne_d;
    pisv_byte_t  railTwo_q;
    pisv_byte_t  railTwo_d;
    logic        hotPrev_q;
    logic [1:0]  pg_q;
    logic [1:0]  pg_d;
    logic        irq_q;
    logic        irq_d;
    logic [6:0]  flagSet;
    logic [6:0]  flagClr;
    logic [6:0]  flags;
    logic [3:0]  cause;
    logic        fltFlag;
    logic        shutFlag;
    logic        hotFlag;
    logic        hotRise;

    // ==========================================================
    // serial port state
    pisv_state_e state_q;
    pisv_state_e state_d;
    pisv_byte_t  shift_q;
    pisv_byte_t  shift_d;
    logic [3:0]  bitCnt_q;
    logic [3:0]  bitCnt_d;
    pisv_byte_t  ptr_q;
    pisv_byte_t  ptr_d;
    logic        rw_q;
    logic        rw_d;
    logic        oe_q;
    logic        oe_d;
    logic        sclPrev_q;
    logic        sdaPrev_q;
    logic        wrEn;
    pisv_byte_t  rdByte;
    logic        sclRise;
    logic        sclFall;
    logic        startCond;
    logic        stopCond;

    assign cause    = flags[3:0];
    assign hotFlag  = flags[4];
    assign shutFlag = flags[5];
    assign fltFlag  = flags[6];
    assign hotRise  = hotAbove & ~hotPrev_q;

    // ==========================================================
    // read decode, shared by address and read acknowledge
    function automatic pisv_byte_t readReg(input pisv_byte_t addr);
        pisv_byte_t r;
        r = `PISV_RD_UNMAPPED;
        case (addr)
            `PISV_OFS_FLAGS: begin
                r[`PISV_BIT_FAULT] = fltFlag;
                r[`PISV_BIT_SHUT]  = shutFlag;
                r[`PISV_BIT_HOT]   = hotFlag;
            end
            `PISV_OFS_MASK: begin
                r = `PISV_RST_MASK;
                r[`PISV_BIT_FAULT] = mask_q[2];
                r[`PISV_BIT_SHUT]  = mask_q[1];
                r[`PISV_BIT_HOT]   = mask_q[0];
            end
            `PISV_OFS_STATUS: r[0] = hotAbove;
            `PISV_OFS_CAUSE:  r[3:0] = cause;
            `PISV_OFS_RAIL1:  r = railOne_q;
            `PISV_OFS_RAIL2:  r = railTwo_q;
            default:          r = `PISV_RD_UNMAPPED;
        endcase
        return r;
    endfunction

    // ==========================================================
    // serial port; scl and sda are taken as synchronous inputs
    assign sclRise   = scl & ~sclPrev_q;
    assign sclFall   = ~scl & sclPrev_q;
    assign startCond = scl & sclPrev_q & sdaPrev_q & ~sdaIn;
    assign stopCond  = scl & sclPrev_q & ~sdaPrev_q & sdaIn;

    always_comb begin
        state_d  = state_q;
        shift_d  = shift_q;
        bitCnt_d = bitCnt_q;
        ptr_d    = ptr_q;
        rw_d     = rw_q;
        oe_d     = oe_q;
        wrEn     = 1'b0;
        rdByte   = readReg(ptr_q);
        if (startCond) begin
            state_d  = ST_ADDR;
            bitCnt_d = 4'h0;
            oe_d     = 1'b0;
        end else if (stopCond) begin
            state_d = ST_IDLE;
            oe_d    = 1'b0;
        end else begin
            case (state_q)
                ST_IDLE: begin
                    oe_d = 1'b0;
                end
                ST_ADDR, ST_PTR, ST_WDATA: begin
                    if (sclRise) begin
                        shift_d  = {shift_q[6:0], sdaIn};
                        bitCnt_d = bitCnt_q + 4'h1;
                    end else if (sclFall && bitCnt_q == `PISV_BYTE_BITS) begin
                        oe_d = 1'b1;
                        case (state_q)
                            ST_ADDR: begin
                                rw_d    = shift_q[0];
                                oe_d    = (shift_q[7:1] == DEV_ADDR);
                                state_d = (shift_q[7:1] == DEV_ADDR) ?
                                          ST_ADDR_ACK : ST_IDLE;
                            end
                            ST_PTR: begin
                                ptr_d   = shift_q;
                                state_d = ST_PTR_ACK;
                            end
                            default: begin
                                wrEn    = 1'b1;
                                ptr_d   = ptr_q + 8'h01;
                                state_d = ST_WDATA_ACK;
                            end
                        endcase
                    end
                end
                ST_ADDR_ACK: begin
                    if (sclFall) begin
                        bitCnt_d = 4'h0;
                        if (rw_q) begin
                            shift_d = rdByte;
                            oe_d    = ~rdByte[7];
                            state_d = ST_RDATA;
                        end else begin
                            oe_d    = 1'b0;
                            state_d = ST_PTR;
                        end
                    end
                end
                ST_PTR_ACK, ST_WDATA_ACK: begin
                    if (sclFall) begin
                        oe_d     = 1'b0;
                        bitCnt_d = 4'h0;
                        state_d  = ST_WDATA;
                    end
                end
                ST_RDATA: begin
                    if (sclRise) begin
                        bitCnt_d = bitCnt_q + 4'h1;
                    end else if (sclFall) begin
                        if (bitCnt_q == `PISV_BYTE_BITS) begin
                            oe_d    = 1'b0;
                            ptr_d   = ptr_q + 8'h01;
                            state_d = ST_RDATA_ACK;
                        end else begin
                            shift_d = {shift_q[6:0], 1'b0};
                            oe_d    = ~shift_q[6];
                        end
                    end
                end
                ST_RDATA_ACK: begin
                    // a nack from the host ends the read; wait for stop
                    if (sclRise && sdaIn) begin
                        state_d = ST_IDLE;
                    end else if (sclFall) begin
                        bitCnt_d = 4'h0;
                        shift_d  = rdByte;
                        oe_d     = ~rdByte[7];
                        state_d  = ST_RDATA;
                    end
                end
                default: begin
                    state_d = ST_IDLE;
                    oe_d    = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state_q   <= ST_IDLE;
            shift_q   <= 8'h00;
            bitCnt_q  <= 4'h0;
            ptr_q     <= 8'h00;
            rw_q      <= 1'b0;
            oe_q      <= 1'b0;
            sclPrev_q <= 1'b1;
            sdaPrev_q <= 1'b1;
        end else begin
            state_q   <= state_d;
            shift_q   <= shift_d;
            bitCnt_q  <= bitCnt_d;
            ptr_q     <= ptr_d;
            rw_q      <= rw_d;
            oe_q      <= oe_d;
            sclPrev_q <= scl;
            sdaPrev_q <= sdaIn;
        end
    end

    // open drain: only ever pulls low
    assign sdaOut = 1'b0;
    assign sdaOe  = oe_q;

    // ==========================================================
    // flag sources and write-one clears
    always_comb begin
        flagSet = '0;
        flagClr = '0;
        flagSet[`PISV_BIT_HOSTOFF] = shutEvents.hostOff;
        flagSet[`PISV_BIT_UV]      = shutEvents.undervoltage;
        flagSet[`PISV_BIT_PF]      = shutEvents.powerFault;
        flagSet[`PISV_BIT_CRIT]    = shutEvents.criticalTemp;
        flagSet[4] = hotRise;
        flagSet[5] = |{shutEvents.hostOff, shutEvents.undervoltage,
                       shutEvents.powerFault, shutEvents.criticalTemp};
        flagSet[6] = shutEvents.powerFault | shutEvents.criticalTemp | hotRise;
        if (wrEn && ptr_q == `PISV_OFS_CAUSE) begin
            flagClr[3:0] = shift_q[3:0];
        end
        if (wrEn && ptr_q == `PISV_OFS_FLAGS) begin
            flagClr[4] = shift_q[`PISV_BIT_HOT];
            flagClr[5] = shift_q[`PISV_BIT_SHUT];
            flagClr[6] = shift_q[`PISV_BIT_FAULT];
        end
    end

    pisv_sticky_bits #(
        .WIDTH     (7)
    ) u_flags (
        .clock     (clock),
        .rst       (rst),
        .setBits   (flagSet),
        .clearBits (flagClr),
        .flags     (flags)
    );

    // ==========================================================
    // writable registers, power good and interrupt
    always_comb begin
        mask_d    = mask_q;
        railOne_d = railOne_q;
        railTwo_d = railTwo_q;
        if (wrEn) begin
            case (ptr_q)
                `PISV_OFS_MASK: begin
                    mask_d = {shift_q[`PISV_BIT_FAULT],
                              shift_q[`PISV_BIT_SHUT],
                              shift_q[`PISV_BIT_HOT]};
                end
                // reserved bit 7 is stored as written
                `PISV_OFS_RAIL1: railOne_d = shift_q;
                `PISV_OFS_RAIL2: railTwo_d = shift_q;
                default: begin
                    mask_d = mask_q;
                end
            endcase
        end
        // zero code turns the rail off; its power good is held high
        pg_d[0] = (railOne_q[6:0] == 7'h00) | ~standbyRequestN | railGoodIn[0];
        pg_d[1] = (railTwo_q[6:0] == 7'h00) | ~standbyRequestN | railGoodIn[1];
        irq_d = |({fltFlag, shutFlag, hotFlag} & ~mask_q);
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            mask_q    <= 3'h7;
            railOne_q <= `PISV_RST_RAIL1;
            railTwo_q <= `PISV_RST_RAIL2;
            hotPrev_q <= 1'b0;
            pg_q      <= 2'h3;
            irq_q     <= 1'b0;
        end else begin
            mask_q    <= mask_d;
            railOne_q <= railOne_d;
            railTwo_q <= railTwo_d;
            hotPrev_q <= hotAbove;
            pg_q      <= pg_d;
            irq_q     <= irq_d;
        end
    end

    assign railOneCode = railOne_q[`PISV_CODE_MSB:0];
    assign railTwoCode = railTwo_q[`PISV_CODE_MSB:0];
    assign powerGood   = pg_q;
    assign irqRequest  = irq_q;

    // ==========================================================
    // checks
    chk_mask_reset: assert property (@(posedge clock)
        rst |=> readReg(`PISV_OFS_MASK) == `PISV_RST_MASK)
        else $error("mask register not all ones after reset");
    chk_shut_mask: assert property (@(posedge clock) disable iff (rst)
        (shutFlag && !fltFlag && !hotFlag && mask_q[1]) |=> !irqRequest)
        else $error("masked shutdown flag raised interrupt");
    chk_hot_mask: assert property (@(posedge clock) disable iff (rst)
        (hotFlag && !mask_q[0]) |=> irqRequest)
        else $error("unmasked hot flag gave no interrupt");
    chk_hot_status: assert property (@(posedge clock)
        readReg(`PISV_OFS_STATUS) == {7'h00, hotAbove})
        else $error("status register does not follow hot level");
    chk_hostoff_set: assert property (@(posedge clock) disable iff (rst)
        shutEvents.hostOff |=> cause[3] && shutFlag)
        else $error("host off did not set its cause");
    chk_cause_keep: assert property (@(posedge clock) disable iff (rst)
        1'b1 |=> (cause & $past(cause & ~flagClr[3:0]))
                 == $past(cause & ~flagClr[3:0]))
        else $error("cause flag lost without a clear");
    chk_uv_set: assert property (@(posedge clock) disable iff (rst)
        shutEvents.undervoltage |=> cause[2] && shutFlag)
        else $error("undervoltage did not set cause and flag");
    chk_pf_set: assert property (@(posedge clock) disable iff (rst)
        shutEvents.powerFault |=> cause[1] && shutFlag && fltFlag)
        else $error("power fault did not set cause and flags");
    chk_crit_set: assert property (@(posedge clock) disable iff (rst)
        shutEvents.criticalTemp |=> cause[0] && shutFlag)
        else $error("critical temperature did not set cause and flag");
    chk_rail_reset: assert property (@(posedge clock)
        rst |=> railOneCode == 7'h38 && railTwoCode == 7'h00)
        else $error("rail codes wrong after reset");
    chk_pgood_hold: assert property (@(posedge clock) disable iff (rst)
        (!standbyRequestN || railTwoCode == 7'h00) |=> powerGood[1])
        else $error("power good dropped while forced high");
    chk_hot_flag: assert property (@(posedge clock) disable iff (rst)
        $rose(hotAbove) |=> hotFlag ##1 (hotFlag || $past(flagClr[4])))
        else $error("hot crossing did not latch its flag");
    chk_irq_cause: assert property (@(posedge clock) disable iff (rst)
        irqRequest |-> $past(|({fltFlag, shutFlag, hotFlag} & ~mask_q)))
        else $error("interrupt without an unmasked flag");

endmodule

`default_nettype wire

// *** sim/pisv_i2c_host.sv ***
// i2c host model: drives scl and pulls sda low, open drain
`timescale 1ns/1ps
`default_nettype none

module pisv_i2c_host (
    input  wire logic clock,
    input  wire logic sdaLine,
    output var  logic scl,
    output var  logic sdaPull
);
    // ==========================================================
    // bit level, every change lands on a falling clock edge
    initial begin
        scl = 1'b1;
        sdaPull = 1'b0;
    end

    task automatic tick(input int n);
        repeat (n) @(negedge clock);
    endtask

    // sda moves only mid low phase, two clocks clear of scl edges
    task automatic bitOut(input logic b);
        tick(2);
        sdaPull = ~b;
        tick(2);
        scl = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask

    // released sda floats to the pull-up level, never the last value
    task automatic bitIn(output logic b);
        tick(2);
        sdaPull = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(3);
        b = sdaLine;
        tick(1);
        scl = 1'b0;
    endtask

    // ==========================================================
    // framing
    task automatic start();
        tick(2);
        sdaPull = 1'b0;
        tick(2);
        scl = 1'b1;
        tick(4);
        sdaPull = 1'b1;
        tick(4);
        scl = 1'b0;
    endtask

    task automatic stop();
        tick(2);
        sdaPull = 1'b1;
        tick(2);
        scl = 1'b1;
        tick(4);
        sdaPull = 1'b0;
        tick(4);
    endtask

    task automatic sendByte(input logic [7:0] b, output logic ack);
        logic nack;
        for (int i = 7; i >= 0; i--) begin
            bitOut(b[i]);
        end
        bitIn(nack);
        ack = ~nack;
    endtask

    task automatic recvByte(output logic [7:0] b, input logic last);
        for (int i = 7; i >= 0; i--) begin
            bitIn(b[i]);
        end
        bitOut(last);
    endtask
endmodule

`default_nettype wire

// *** sim/pisv_regs_bench.sv ***
// self-checking bench of the register slice over i2c
`timescale 1ns/1ps
`default_nettype none

module pisv_regs_bench
    import pisv_pkg::*;
;
    localparam logic [6:0] ADDR = 7'h2A;
    logic         clock;
    logic         rst;
    logic         hotAbove;
    logic         standbyRequestN;
    logic [1:0]   railGoodIn;
    pisv_events_s shutEvents;
    logic         scl;
    logic         sdaPull;
    logic         sdaOut;
    logic         sdaOe;
    wire logic    sdaLine;
    logic [6:0]   railOneCode;
    logic [6:0]   railTwoCode;
    logic [1:0]   powerGood;
    logic         irqRequest;
    logic [7:0]   rd;
    int           badCount;
    int           totalChecks;
    int           cycles;

    // open drain with pull-up: low if either party pulls
    assign sdaLine = ~(sdaPull | (sdaOe & ~sdaOut));

    pisv_regs #(.DEV_ADDR(ADDR)) pisv_regs_inst (
        .clock(clock), .rst(rst), .scl(scl), .sdaIn(sdaLine),
        .sdaOut(sdaOut), .sdaOe(sdaOe), .shutEvents(shutEvents),
        .hotAbove(hotAbove), .standbyRequestN(standbyRequestN),
        .railGoodIn(railGoodIn), .railOneCode(railOneCode),
        .railTwoCode(railTwoCode), .powerGood(powerGood),
        .irqRequest(irqRequest)
    );

    pisv_i2c_host pisv_i2c_host_inst (
        .clock(clock), .sdaLine(sdaLine), .scl(scl), .sdaPull(sdaPull)
    );

    // ==========================================================
    // clock, timeout and verdict
    always #5 clock = ~clock;

    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 40000) begin
            badCount++;
            $display("MISMATCH at %0t: run timed out", $time);
            endSim();
        end
    end

    task automatic endSim();
        if (badCount == 0 && totalChecks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        totalChecks++;
        if (got !== exp) begin
            badCount++;
            $display("MISMATCH at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // ==========================================================
    // register access, every byte the host sends must be acknowledged
    task automatic regWrite(input logic [7:0] ofs, input logic [7:0] val);
        logic a0, a1, a2;
        pisv_i2c_host_inst.start();
        pisv_i2c_host_inst.sendByte({ADDR, 1'b0}, a0);
        pisv_i2c_host_inst.sendByte(ofs, a1);
        pisv_i2c_host_inst.sendByte(val, a2);
        pisv_i2c_host_inst.stop();
        check({5'h00, a0, a1, a2}, 8'h07);
    endtask

    task automatic expectReg(input logic [7:0] ofs, input logic [7:0] exp);
        logic a0, a1, a2;
        pisv_i2c_host_inst.start();
        pisv_i2c_host_inst.sendByte({ADDR, 1'b0}, a0);
        pisv_i2c_host_inst.sendByte(ofs, a1);
        pisv_i2c_host_inst.start();
        pisv_i2c_host_inst.sendByte({ADDR, 1'b1}, a2);
        pisv_i2c_host_inst.recvByte(rd, 1'b1);
        pisv_i2c_host_inst.stop();
        check({5'h00, a0, a1, a2}, 8'h07);
        check(rd, exp);
    endtask

    // ==========================================================
    // main sequence
    initial begin
        clock = 1'b0;
        rst = 1'b1;
        hotAbove = 1'b0;
        standbyRequestN = 1'b1;
        railGoodIn = 2'b11;
        shutEvents = '0;
        badCount = 0;
        totalChecks = 0;
        cycles = 0;
        repeat (16) @(negedge clock);
        rst = 1'b0;
        @(negedge clock);
        check({1'b0, railOneCode}, 8'h38);
        check({6'h00, powerGood}, 8'h03);
        expectReg(8'h03, 8'hFF);
        expectReg(8'h04, 8'h00);
        expectReg(8'h05, 8'h00);
        expectReg(8'h20, 8'h38);
        expectReg(8'h21, 8'h00);
        expectReg(8'h02, 8'h00);
        expectReg(8'h10, 8'h00);
        regWrite(8'h03, 8'h00);
        expectReg(8'h03, 8'h76);
        regWrite(8'h03, 8'hFF);
        hotAbove = 1'b1;
        expectReg(8'h04, 8'h01);
        regWrite(8'h04, 8'hFE);
        expectReg(8'h04, 8'h01);
        expectReg(8'h02, 8'h81);
        check({7'h00, irqRequest}, 8'h00);
        regWrite(8'h03, 8'hFE);
        check({7'h00, irqRequest}, 8'h01);
        regWrite(8'h02, 8'h81);
        expectReg(8'h02, 8'h00);
        check({7'h00, irqRequest}, 8'h00);
        hotAbove = 1'b0;
        expectReg(8'h04, 8'h00);
        for (int i = 0; i < 4; i++) begin
            regWrite(8'h03, 8'h7F);
            @(negedge clock);
            shutEvents = pisv_events_s'(4'h1 << i);
            @(negedge clock);
            shutEvents = '0;
            repeat (2) @(negedge clock);
            check({7'h00, irqRequest}, {7'h00, i < 2});
            expectReg(8'h05, 8'h01 << i);
            expectReg(8'h02, (i < 2) ? 8'h88 : 8'h08);
            regWrite(8'h03, 8'hF7);
            check({7'h00, irqRequest}, 8'h01);
            regWrite(8'h05, 8'h00);
            expectReg(8'h05, 8'h01 << i);
            regWrite(8'h05, 8'hFF);
            regWrite(8'h02, 8'hFF);
            expectReg(8'h05, 8'h00);
            check({7'h00, irqRequest}, 8'h00);
        end
        railGoodIn = 2'b00;
        regWrite(8'h20, 8'h00);
        check({1'b0, railOneCode}, 8'h00);
        check({6'h00, powerGood}, 8'h03);
        regWrite(8'h21, 8'h45);
        expectReg(8'h21, 8'h45);
        check({1'b0, railTwoCode}, 8'h45);
        check({6'h00, powerGood}, 8'h01);
        standbyRequestN = 1'b0;
        repeat (2) @(negedge clock);
        check({6'h00, powerGood}, 8'h03);
        regWrite(8'h20, 8'h7F);
        expectReg(8'h20, 8'h7F);
        check({1'b0, railOneCode}, 8'h7F);
        endSim();
    end
endmodule

`default_nettype wire
